// ### hdl/dfo_top.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module dfo_top
  import dfo_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Modulator bit stream from the front end.
  input wire logic mod_bit,
  // AHB-Lite register slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Output samples and interrupt.
  output var dfo_sample_t sample_out,
  output logic sample_strobe,
  output logic irq
);
  typedef struct packed {
    logic [1:0] sync;
    dfo_bus_t bus;
    logic [7:0] idx;
    logic wok;
    logic [31:0] rdata;
    logic [2:0] decim;
    logic [6:0] clkcfg;
    logic [11:0] limit;
    logic frst;
    logic dsr;
    logic [1:0] sel;
    logic [1:0] chan;
    logic signed [GW-1:0] gain_a;
    logic signed [GW-1:0] gain_b;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [15:0] fs_acc;
    logic [13:0] cic_cnt;
    logic [13:0] tk;
    logic signed [ACC_W-1:0] i1;
    logic signed [ACC_W-1:0] i2;
    logic signed [ACC_W-1:0] i3;
    logic signed [ACC_W-1:0] c1;
    logic signed [ACC_W-1:0] c2;
    logic signed [ACC_W-1:0] c3;
    logic signed [DW-1:0] cic_y;
    logic cic_vld;
    dfo_sample_t smp;
    logic strobe;
  } dfo_st_t;

  dfo_st_t st_ff, nxt_st;
  logic [16:0] fs_sum;
  logic fs_tick;
  logic [13:0] cic_last;
  logic signed [ACC_W-1:0] x;
  logic signed [ACC_W-1:0] d1;
  logic signed [ACC_W-1:0] d2;
  logic signed [ACC_W-1:0] d3;
  logic signed [ACC_W-1:0] nrm;
  logic signed [ACC_W-1:0] prod;
  logic signed [DW-1:0] half_y;
  logic signed [DW-1:0] droop_y;
  logic signed [DW-1:0] pick;
  logic signed [DW-1:0] gsat;
  logic signed [DW-1:0] lim;
  logic signed [GW-1:0] gain;
  logic [DW-1:0] bound;
  logic [31:0] rd_word;
  logic half_vld;
  logic droop_vld;
  logic out_vld;
  logic clip;
  logic acc_req;
  logic wr_en;
  logic rd_smp;
  logic [1:0] irq_clr;
  logic [1:0] irq_set;
  logic [2:0] droop_ratio;

  // Half-band stage, always decimating by two.
  dfo_fir3 #(
    .C0(HALF_C0),
    .C1(HALF_C1),
    .SH(HALF_SH)
  ) u_half (
    .mclk(mclk),
    .rstn(rstn),
    .clear(st_ff.frst),
    .ratio(HALF_DEC),
    .in_valid(st_ff.cic_vld),
    .in_data(st_ff.cic_y),
    .out_valid(half_vld),
    .out_data(half_y)
  );

  // Droop correction boosts the band edge that the comb stage attenuates.
  assign droop_ratio = st_ff.dsr ? DROOP_DEC_R2 : DROOP_DEC_R1;
  dfo_fir3 #(
    .C0(DROOP_C0),
    .C1(DROOP_C1),
    .SH(DROOP_SH)
  ) u_droop (
    .mclk(mclk),
    .rstn(rstn),
    .clear(st_ff.frst),
    .ratio(droop_ratio),
    .in_valid(half_vld),
    .in_data(half_y),
    .out_valid(droop_vld),
    .out_data(droop_y)
  );

  // Sampling tick, comb arithmetic, output scaling and the read mux.
  always_comb begin
    fs_sum = 17'(st_ff.fs_acc) + 17'(st_ff.clkcfg);
    fs_tick = fs_sum >= 17'(FS_MOD);
    cic_last = 14'((15'h1 << (4'(st_ff.decim) + 4'(CIC_LOG2))) - 15'h1);
    x = st_ff.sync[1] ? ACC_W'(1) : -ACC_W'(1);
    d1 = st_ff.i3 - st_ff.c1;
    d2 = d1 - st_ff.c2;
    d3 = d2 - st_ff.c3;
    nrm = (d3 <<< CIC_NORM_SH) >>> (6'(st_ff.decim) * 6'h3);
    // A bypassed stage neither filters nor decimates, so the rate follows the pick.
    case (st_ff.sel)
      SEL_HALF: {pick, out_vld} = {half_y, half_vld};
      SEL_CIC: {pick, out_vld} = {st_ff.cic_y, st_ff.cic_vld};
      default: {pick, out_vld} = {droop_y, droop_vld};
    endcase
    gain = (st_ff.chan == CHAN_B) ? st_ff.gain_b : st_ff.gain_a;
    prod = (ACC_W'(pick) * ACC_W'(gain)) >>> GAIN_SH;
    if (prod > ACC_W'(SMAX)) begin
      gsat = SMAX[DW-1:0];
    end else if (prod < ACC_W'(SMIN)) begin
      gsat = SMIN[DW-1:0];
    end else begin
      gsat = prod[DW-1:0];
    end
    bound = {1'b0, st_ff.limit, LIM_FILL};
    lim = gsat;
    clip = 1'b0;
    if (st_ff.limit != LIMIT_MAX) begin
      if (gsat > $signed(bound)) begin
        lim = $signed(bound);
        clip = 1'b1;
      end else if (gsat < -$signed(bound)) begin
        lim = -$signed(bound);
        clip = 1'b1;
      end
    end
    rd_word = 32'h0;
    case (st_ff.idx)
      IX_DECIM: rd_word[DECIM_LO +: 3] = st_ff.decim;
      IX_CLK: rd_word[CLK_LO +: 7] = st_ff.clkcfg;
      IX_LIMIT: rd_word[LIMIT_LO +: 12] = st_ff.limit;
      IX_CHAN: rd_word[CHAN_LO +: 2] = st_ff.chan;
      IX_GAIN_B: rd_word[GAIN_B_LO +: GW] = st_ff.gain_b;
      IX_FRST: begin
        rd_word[FRST_BIT] = st_ff.frst;
        rd_word[GAIN_A_LO +: GW] = st_ff.gain_a;
      end
      IX_DSR: begin
        rd_word[DSR_BIT] = st_ff.dsr;
        rd_word[SEL_LO +: 2] = st_ff.sel;
      end
      IX_SAMPLE: rd_word[DW:0] = st_ff.smp;
      IX_IRQ_ST: rd_word[1:0] = st_ff.irq_st;
      IX_IRQ_MASK: rd_word[1:0] = st_ff.irq_mask;
      default: rd_word = 32'h0;
    endcase
  end

  // Next state: bus slave, register writes, filter chain and sample output.
  always_comb begin
    nxt_st = st_ff;
    acc_req = hsel && hready && htrans[1];
    wr_en = 1'b0;
    rd_smp = 1'b0;
    irq_set = 2'h0;
    nxt_st.sync = {st_ff.sync[0], mod_bit};
    nxt_st.fs_acc = fs_tick ? 16'(fs_sum - 17'(FS_MOD)) : fs_sum[15:0];
    nxt_st.cic_vld = 1'b0;
    nxt_st.strobe = 1'b0;
    case (st_ff.bus)
      BUS_RD: begin
        nxt_st.rdata = rd_word;
        rd_smp = (st_ff.idx == IX_SAMPLE);
        nxt_st.bus = BUS_RDY;
      end
      default: begin
        wr_en = (st_ff.bus == BUS_WR) && st_ff.wok;
        if (acc_req) begin
          nxt_st.idx = haddr[9:2];
          nxt_st.wok = (hsize == HSIZE_WORD);
          nxt_st.bus = hwrite ? BUS_WR : BUS_RD;
        end else begin
          nxt_st.bus = BUS_IDLE;
        end
      end
    endcase
    if (wr_en) begin
      case (st_ff.idx)
        IX_DECIM: nxt_st.decim = hwdata[DECIM_LO +: 3];
        IX_CLK: nxt_st.clkcfg = hwdata[CLK_LO +: 7];
        IX_LIMIT: nxt_st.limit = hwdata[LIMIT_LO +: 12];
        IX_CHAN: nxt_st.chan = hwdata[CHAN_LO +: 2];
        IX_GAIN_B: nxt_st.gain_b = hwdata[GAIN_B_LO +: GW];
        IX_FRST: begin
          nxt_st.frst = hwdata[FRST_BIT];
          nxt_st.gain_a = hwdata[GAIN_A_LO +: GW];
        end
        IX_DSR: begin
          nxt_st.dsr = hwdata[DSR_BIT];
          nxt_st.sel = hwdata[SEL_LO +: 2];
        end
        IX_IRQ_MASK: nxt_st.irq_mask = hwdata[1:0];
        default: nxt_st.irq_mask = st_ff.irq_mask;
      endcase
    end
    irq_clr = (wr_en && st_ff.idx == IX_IRQ_ST) ? hwdata[1:0] : 2'h0;
    // Comb-integrator stage; the filter reset keeps every accumulator clear.
    if (st_ff.frst) begin
      nxt_st.i1 = '0;
      nxt_st.i2 = '0;
      nxt_st.i3 = '0;
      nxt_st.c1 = '0;
      nxt_st.c2 = '0;
      nxt_st.c3 = '0;
      nxt_st.cic_cnt = 14'h0;
      nxt_st.tk = 14'h0;
      nxt_st.cic_y = '0;
    end else if (fs_tick) begin
      nxt_st.i1 = st_ff.i1 + x;
      nxt_st.i2 = st_ff.i2 + st_ff.i1;
      nxt_st.i3 = st_ff.i3 + st_ff.i2;
      nxt_st.tk = st_ff.tk + 14'h1;
      if (st_ff.cic_cnt >= cic_last) begin
        nxt_st.cic_cnt = 14'h0;
        nxt_st.c1 = st_ff.i3;
        nxt_st.c2 = d1;
        nxt_st.c3 = d2;
        nxt_st.cic_y = nrm[DW-1:0];
        nxt_st.cic_vld = 1'b1;
      end else begin
        nxt_st.cic_cnt = st_ff.cic_cnt + 14'h1;
      end
    end else if (st_ff.cic_vld) begin
      nxt_st.tk = 14'h0;
    end
    // Output word; a new sample beats a read that clears data-ready.
    if (out_vld && !st_ff.frst) begin
      nxt_st.smp.data = lim;
      nxt_st.strobe = 1'b1;
      irq_set[IRQ_SAMPLE] = 1'b1;
      irq_set[IRQ_CLIP] = clip;
    end
    nxt_st.smp.ready = (st_ff.smp.ready & ~rd_smp) | irq_set[IRQ_SAMPLE];
    if (st_ff.frst) begin
      nxt_st.smp.ready = 1'b0;
    end
    nxt_st.irq_st = (st_ff.irq_st & ~irq_clr) | irq_set;
  end

  // State register with documented reset values.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.decim <= DECIM_RST;
      st_ff.clkcfg <= CLK_RST;
      st_ff.limit <= LIMIT_MAX;
      st_ff.frst <= FRST_RST;
      st_ff.chan <= CHAN_B;
      st_ff.gain_a <= GAIN_RST;
      st_ff.gain_b <= GAIN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs.
  assign hreadyout = (st_ff.bus != BUS_RD);
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign sample_out = st_ff.smp;
  assign sample_strobe = st_ff.strobe;
  assign irq = |(st_ff.irq_st & st_ff.irq_mask);

  // Stage order: half-band output follows a comb output.
  property p_order;
    @(posedge mclk) disable iff (!rstn)
      half_vld |-> $past(st_ff.cic_vld);
  endproperty
  a_order: assert property (p_order)
    else $error("Half-band output without comb input.");

  // Comb decimation spans two to the factor plus six sampling ticks.
  property p_cic_rate;
    @(posedge mclk) disable iff (!rstn)
      st_ff.cic_vld && !$past(st_ff.frst) |-> st_ff.tk == $past(cic_last) + 14'h1;
  endproperty
  a_cic_rate: assert property (p_cic_rate)
    else $error("Comb decimation count wrong.");

  // Phase accumulator stays below its modulus.
  property p_fs;
    @(posedge mclk) disable iff (!rstn)
      st_ff.fs_acc < FS_MOD;
  endproperty
  a_fs: assert property (p_fs)
    else $error("Sampling accumulator overflow.");

  // Limited samples stay within the programmed bound.
  property p_limit;
    @(posedge mclk) disable iff (!rstn)
      st_ff.strobe && $past(st_ff.limit) != LIMIT_MAX |->
        $signed(st_ff.smp.data) <= $signed($past(bound)) &&
        $signed(st_ff.smp.data) >= -$signed($past(bound));
  endproperty
  a_limit: assert property (p_limit)
    else $error("Sample exceeds output limit.");

  // At the maximum limit the gained word passes unchanged.
  property p_pass;
    @(posedge mclk) disable iff (!rstn)
      out_vld && !st_ff.frst && st_ff.limit == LIMIT_MAX |=> st_ff.smp.data == $past(gsat);
  endproperty
  a_pass: assert property (p_pass)
    else $error("Unlimited sample was altered.");

  // The filter reset silences the droop stage from the next cycle.
  property p_frst;
    @(posedge mclk) disable iff (!rstn)
      st_ff.frst |=> !droop_vld && !half_vld;
  endproperty
  a_frst: assert property (p_frst)
    else $error("Filter produced output under reset.");

  // Accumulators clear and data-ready low while the filter reset holds.
  property p_hold;
    @(posedge mclk) disable iff (!rstn)
      st_ff.frst |=> st_ff.i3 == '0 && st_ff.cic_cnt == 14'h0 && !st_ff.smp.ready && !st_ff.strobe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Filter state not held in reset.");

  // Each accepted output of the picked stage becomes a ready sample and a sticky event.
  property p_ready;
    @(posedge mclk) disable iff (!rstn)
      out_vld && !st_ff.frst |=> st_ff.strobe && st_ff.smp.ready && st_ff.irq_st[IRQ_SAMPLE];
  endproperty
  a_ready: assert property (p_ready)
    else $error("Sample not presented with data-ready.");
endmodule
`default_nettype wire

// ### common/dfo_pkg.sv
package dfo_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int FS_STEP_HZ = 4_000;
  localparam logic [15:0] FS_MOD = 16'(CLK_HZ / FS_STEP_HZ);
  localparam int ACC_W = 48;
  localparam int DW = 24;
  localparam int GW = 20;
  localparam int CIC_LOG2 = 6;
  localparam int CIC_NORM_SH = DW - 2 - 3 * CIC_LOG2;
  localparam int GAIN_SH = 9;
  localparam logic signed [31:0] SMAX = 32'sh007FFFFF;
  localparam logic signed [31:0] SMIN = 32'shFF800000;
  localparam logic [10:0] LIM_FILL = 11'h7FF;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IX_DECIM = 8'h02;
  localparam logic [7:0] IX_CLK = 8'h05;
  localparam logic [7:0] IX_LIMIT = 8'h07;
  localparam logic [7:0] IX_CHAN = 8'h09;
  localparam logic [7:0] IX_GAIN_B = 8'h1A;
  localparam logic [7:0] IX_FRST = 8'h24;
  localparam logic [7:0] IX_DSR = 8'h2B;
  localparam logic [7:0] IX_SAMPLE = 8'h38;
  localparam logic [7:0] IX_IRQ_ST = 8'h39;
  localparam logic [7:0] IX_IRQ_MASK = 8'h3A;
  // Field positions inside the register words.
  localparam int DECIM_LO = 23;
  localparam int CLK_LO = 25;
  localparam int LIMIT_LO = 20;
  localparam int CHAN_LO = 18;
  localparam int GAIN_B_LO = 12;
  localparam int GAIN_A_LO = 0;
  localparam int FRST_BIT = 26;
  localparam int DSR_BIT = 23;
  localparam int SEL_LO = 21;
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_CLIP = 1;
  // Reset values and codes.
  localparam logic [2:0] DECIM_RST = 3'h3;
  localparam logic [6:0] CLK_RST = 7'h64;
  localparam logic [11:0] LIMIT_MAX = 12'hFFF;
  localparam logic FRST_RST = 1'b1;
  localparam logic [GW-1:0] GAIN_RST = 20'h001F4;
  localparam logic [1:0] CHAN_B = 2'h2;
  localparam logic [1:0] SEL_HALF = 2'h1;
  localparam logic [1:0] SEL_CIC = 2'h2;
  localparam logic [2:0] HALF_DEC = 3'h2;
  localparam logic [2:0] DROOP_DEC_R1 = 3'h2;
  localparam logic [2:0] DROOP_DEC_R2 = 3'h4;
  localparam int HALF_C0 = 1;
  localparam int HALF_C1 = 2;
  localparam int HALF_SH = 2;
  localparam int DROOP_C0 = -1;
  localparam int DROOP_C1 = 10;
  localparam int DROOP_SH = 3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic ready;
    logic [DW-1:0] data;
  } dfo_sample_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD, BUS_RDY} dfo_bus_t;
endpackage

// ### hdl/dfo_fir3.sv
`timescale 1ns/10ps
`default_nettype none
module dfo_fir3
  import dfo_pkg::*;
#(
  parameter int C0 = 1,
  parameter int C1 = 2,
  parameter int SH = 2
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Control.
  input wire logic clear,
  input wire logic [2:0] ratio,
  // Input samples.
  input wire logic in_valid,
  input wire logic signed [DW-1:0] in_data,
  // Output samples.
  output logic out_valid,
  output logic signed [DW-1:0] out_data
);
  typedef struct packed {
    logic signed [DW-1:0] x1;
    logic signed [DW-1:0] x2;
    logic [2:0] cnt;
    logic vld;
    logic signed [DW-1:0] y;
  } dfo_fir_st_t;

  dfo_fir_st_t st_ff, nxt_st;
  logic signed [31:0] acc;
  logic signed [31:0] shd;

  // Symmetric three-tap sum, scaled, saturated and kept every ratio-th input.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.vld = 1'b0;
    acc = 32'(C0) * 32'(in_data) + 32'(C1) * 32'(st_ff.x1) + 32'(C0) * 32'(st_ff.x2);
    shd = acc >>> SH;
    if (clear) begin
      nxt_st = '0;
    end else if (in_valid) begin
      nxt_st.x1 = in_data;
      nxt_st.x2 = st_ff.x1;
      if (st_ff.cnt >= ratio - 3'h1) begin
        nxt_st.cnt = 3'h0;
        nxt_st.vld = 1'b1;
        if (shd > SMAX) begin
          nxt_st.y = SMAX[DW-1:0];
        end else if (shd < SMIN) begin
          nxt_st.y = SMIN[DW-1:0];
        end else begin
          nxt_st.y = shd[DW-1:0];
        end
      end else begin
        nxt_st.cnt = st_ff.cnt + 3'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign out_valid = st_ff.vld;
  assign out_data = st_ff.y;

  // An output follows the last input of each decimation group.
  property p_fir_decim;
    @(posedge mclk) disable iff (!rstn)
      in_valid && !clear && st_ff.cnt == ratio - 3'h1 |=> out_valid;
  endproperty
  a_fir_decim: assert property (p_fir_decim)
    else $error("Decimated output missing.");
endmodule
`default_nettype wire

// ### bench/dfo_fe_model.sv
`timescale 1ns/10ps
`default_nettype none
module dfo_fe_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Stream control and modulator output.
  input wire logic [1:0] mode,
  output logic mod_bit
);
  // One bit per clock: mode 0 gives minus one, mode 1 plus one, else a random stream.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mod_bit <= 1'b0;
    end else begin
      mod_bit <= (mode == 2'h0) ? 1'b0 : (mode == 2'h1) ? 1'b1 : 1'($urandom);
    end
  end
endmodule
`default_nettype wire

// ### bench/test_decimation_filter_output.sv
`timescale 1ns/10ps
`default_nettype none
module test_decimation_filter_output
  import dfo_pkg::*;
;
  // A clock field of 125 gives one sampling tick every 200 clocks.
  localparam logic [6:0] FS_CFG = 7'h7D;
  localparam time COMB_NS = 64 * 200 * 10;
  localparam logic [23:0] POS_CLAMP = 24'h0087FF;
  localparam logic [23:0] NEG_CLAMP = 24'hFF7801;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rdv;
  logic [31:0] rnd;
  logic [1:0] htrans = 2'h0;
  logic [1:0] fe_mode = 2'h1;
  logic [2:0] hsize = 3'h0;
  logic hreadyout, hresp, sample_strobe, irq, mod_bit, ok;
  dfo_sample_t sample_out;
  int bad_count = 0;
  int compares = 0;
  int n_strobe = 0;
  int seen;
  time t_last = 0;
  time t_prev = 0;
  logic [24:0] e;
  logic [24:0] exp_q[$];
  logic [7:0] rix [8] = '{IX_DECIM, IX_CLK, IX_LIMIT, IX_CHAN, IX_GAIN_B, IX_FRST, IX_DSR, 8'h3F};
  logic [31:0] rval [8] = '{32'h01800000, 32'hC8000000, 32'hFFF00000, 32'h00080000,
                            32'h001F4000, 32'h040001F4, 32'h00000000, 32'h00000000};

  // Free-running clock; the single slave's ready is the bus ready.
  always #5 mclk = ~mclk;
  assign hready = hreadyout;

  dfo_top u_dfo_top (.mclk(mclk), .rstn(rstn), .mod_bit(mod_bit), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_out(sample_out),
    .sample_strobe(sample_strobe), .irq(irq));

  dfo_fe_model u_dfo_fe_model (.mclk(mclk), .rstn(rstn), .mode(fe_mode), .mod_bit(mod_bit));

  task automatic fail(input string msg);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Waits for ready seen at a settled point, then lets the accepting edge pass.
  task automatic wait_rdy(output logic [31:0] rd);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (hreadyout !== 1'b1) begin
      fail("bus wait timed out");
      give_verdict();
    end else begin
      @(posedge mclk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] ix, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, ix, 2'h0};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
    ahb(1'b1, ix, wd, rdv);
  endtask

  task automatic chk(input logic [7:0] ix, input logic [31:0] ev);
    logic [31:0] rd;
    ahb(1'b0, ix, 32'h0, rd);
    compares++;
    if (rd !== ev || hresp !== 1'b0) begin
      fail("register read mismatch");
    end
  endtask

  task automatic chk_bit(input logic ev, input string msg);
    @(negedge mclk);
    compares++;
    if (irq !== ev) begin
      fail(msg);
    end
  endtask

  task automatic wait_strobes(input int k);
    int target;
    int n;
    target = n_strobe + k;
    n = 0;
    while (n_strobe < target && n < 16000 * k) begin
      @(negedge mclk);
      n++;
    end
    if (n_strobe < target) begin
      fail("no sample arrived");
      give_verdict();
    end
  endtask

  // Result watcher: each new sample takes the oldest expectation off the queue.
  always @(negedge mclk) begin
    if (sample_strobe === 1'b1) begin
      t_prev = t_last;
      t_last = $time;
      n_strobe++;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        ok = e[24] ? ($signed(sample_out.data) < $signed(NEG_CLAMP)) :
          (sample_out.data === e[23:0]);
        compares++;
        if (ok !== 1'b1 || sample_out.ready !== 1'b1) begin
          fail("sample value mismatch");
        end
      end
    end
  end

  // Main sequence: reset values, clamped stream, interrupt, filter reset, unclamped stream.
  initial begin
    void'($urandom(62));
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk(rix[i], rval[i]);
    end
    rnd = $urandom;
    wr(IX_LIMIT, rnd);
    chk(IX_LIMIT, {rnd[31:20], 20'h0});
    wr(IX_LIMIT, 32'h01000000);
    wr(IX_DECIM, 32'h0);
    wr(IX_CLK, {FS_CFG, 25'h0});
    wr(IX_DSR, {8'h0, 1'b0, SEL_CIC, 21'h0});
    wr(IX_IRQ_MASK, 32'h1);
    wr(IX_FRST, 32'h040001F4);
    wr(IX_FRST, 32'h000001F4);
    exp_q.push_back({1'b0, POS_CLAMP});
    exp_q.push_back({1'b0, POS_CLAMP});
    wait_strobes(2);
    compares++;
    if (t_last - t_prev !== COMB_NS) begin
      fail("sample spacing wrong");
    end
    chk_bit(1'b1, "interrupt not raised");
    chk(IX_IRQ_ST, 32'h3);
    chk(IX_SAMPLE, {7'h0, 1'b1, POS_CLAMP});
    chk(IX_SAMPLE, {8'h0, POS_CLAMP});
    wr(IX_SAMPLE, 32'hFFFFFFFF);
    chk(IX_SAMPLE, {8'h0, POS_CLAMP});
    wr(IX_IRQ_MASK, 32'h0);
    chk_bit(1'b0, "masked interrupt high");
    wr(IX_IRQ_MASK, 32'h1);
    chk_bit(1'b1, "unmasked interrupt low");
    wr(IX_IRQ_ST, 32'h3);
    chk_bit(1'b0, "interrupt not cleared");
    // Filter reset with a random stream: nothing may come out.
    fe_mode <= 2'h2;
    wr(IX_FRST, 32'h040001F4);
    seen = n_strobe;
    repeat (13000) @(negedge mclk);
    compares++;
    if (n_strobe != seen || sample_out.ready !== 1'b0) begin
      fail("output during filter reset");
    end
    chk(IX_IRQ_ST, 32'h0);
    fe_mode <= 2'h0;
    wr(IX_FRST, 32'h000001F4);
    exp_q.push_back({1'b0, NEG_CLAMP});
    wait_strobes(1);
    wr(IX_LIMIT, 32'hFFF00000);
    exp_q.push_back({1'b1, 24'h0});
    wait_strobes(1);
    give_verdict();
  end
endmodule
`default_nettype wire
